/* hdl/simz_mode_regs.sv */
/*
  System-interface mode register zero with its decoded controls,
  master reset sequencing, parity routing and byte order swap.
  Assumes a plain register port and data paths on clk.
*/
`timescale 1ns/1ps
module simz_mode_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [8:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Decoded controls
  output logic             test_mode,
  output logic [7:0]       service_loss_limit,
  output logic             fast_host_clock_opt,
  output logic             machines_stop,
  output logic             sysif_regs_init,
  output logic             virtual_addressing_select,
  output logic [12:0]      queue_bytes,
  output logic [3:0]       burst_max_words,
  output logic             control_bus_parity_enable,
  // Transmit request path from host bus
  input  wire logic [7:0]  host_tx_data,
  input  wire logic        host_tx_par,
  input  wire logic        host_tx_valid,
  output logic [7:0]       req_tx_data,
  output logic             req_tx_par,
  output logic             req_tx_valid,
  // Receive indicate path from ring engine
  input  wire logic [7:0]  ind_rx_data,
  input  wire logic        ind_rx_par,
  input  wire logic        ind_rx_valid,
  input  wire logic        ind_rx_in_frame,
  // Descriptor fetch parity fault
  input  wire logic        desc_par_fault,
  // Host bus word out
  input  wire logic [31:0] host_out_word,
  output logic [31:0]      host_bus_word,
  output logic [3:0]       host_bus_par
);
  import simz_pkg::*;

  logic [7:0]  mode_zero;
  logic [7:0]  next_mode_zero;
  logic [7:0]  ctrl;
  logic        rx_par_err;
  logic        flag_rx_par;
  logic        flag_err;
  logic [3:0]  rst_cnt;
  logic [3:0]  next_rst_cnt;
  simz_rst_e   rst_state;
  simz_rst_e   next_rst_state;
  logic        wr_mode;
  logic        wr_stat;
  logic [31:0] next_word;

  simz_par_if tx_in_b ();
  simz_par_if tx_out_b ();
  simz_par_if rx_in_b ();

  function automatic logic odd_par(input logic [7:0] d);
    return ~(^d);
  endfunction

  function automatic logic [31:0] lane_swap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  assign wr_mode = reg_wr && (reg_addr == MODE_ZERO_OFFSET);
  assign wr_stat = reg_wr && (reg_addr == STAT_OFFSET);

  // Next mode value; final busy cycle clears only the reset bit
  always_comb begin
    next_mode_zero = mode_zero;
    if (rst_state == SIMZ_RST_BUSY && rst_cnt == 4'h0) begin
      next_mode_zero[MASTER_RST_BIT] = 1'b0;
    end else if (wr_mode) begin
      next_mode_zero = reg_wdata;
    end
  end

  // Mode register, master reset bit held until sequence ends
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_zero <= MODE_ZERO_RESET;
    end else begin
      mode_zero <= next_mode_zero;
    end
  end

  // Master reset sequencer, next state
  always_comb begin
    next_rst_state = rst_state;
    next_rst_cnt   = rst_cnt;
    case (rst_state)
      SIMZ_RST_IDLE: begin
        if (wr_mode && reg_wdata[MASTER_RST_BIT]) begin
          next_rst_state = SIMZ_RST_BUSY;
          next_rst_cnt   = MASTER_RST_CYCLES - 4'h1;
        end
      end
      SIMZ_RST_BUSY: begin
        if (rst_cnt == 4'h0) begin
          next_rst_state = SIMZ_RST_IDLE;
        end else begin
          next_rst_cnt = rst_cnt - 4'h1;
        end
      end
      default: begin
        next_rst_state = SIMZ_RST_IDLE;
        next_rst_cnt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rst_state <= SIMZ_RST_IDLE;
      rst_cnt   <= 4'h0;
    end else begin
      rst_state <= next_rst_state;
      rst_cnt   <= next_rst_cnt;
    end
  end

  // Stop level from a flop, loaded from the next state to track rst_state
  always_ff @(posedge clk) begin
    if (srst) begin
      machines_stop <= 1'b0;
    end else begin
      machines_stop <= (next_rst_state == SIMZ_RST_BUSY);
    end
  end

  assign sysif_regs_init = machines_stop;

  // Control register holding control bus parity enable, independent of flow
  always_ff @(posedge clk) begin
    if (srst || machines_stop) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == CTRL_OFFSET) begin
      ctrl <= reg_wdata;
    end
  end

  // Sticky error flags, set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (srst || machines_stop) begin
      flag_rx_par <= 1'b0;
      flag_err    <= 1'b0;
    end else begin
      flag_rx_par <= rx_par_err
                     || (flag_rx_par && !(wr_stat && reg_wdata[STAT_RX_PAR_BIT]));
      flag_err <= desc_par_fault
                  || (flag_err && !(wr_stat && reg_wdata[STAT_ERR_BIT]));
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        MODE_ZERO_OFFSET: reg_rdata <= mode_zero;
        CTRL_OFFSET:      reg_rdata <= ctrl;
        STAT_OFFSET: begin
          reg_rdata                <= 8'h00;
          reg_rdata[STAT_RX_PAR_BIT] <= flag_rx_par;
          reg_rdata[STAT_ERR_BIT]  <= flag_err;
          reg_rdata[STAT_BUSY_BIT] <= machines_stop;
        end
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  assign test_mode                 = mode_zero[TEST_BIT];
  assign fast_host_clock_opt       = mode_zero[FAST_CLK_BIT];
  assign virtual_addressing_select = mode_zero[VIRTUAL_BIT];
  assign control_bus_parity_enable = ctrl[CTRL_BUS_PAR_BIT];

  // Multi-bit controls from flops, loaded in step with the mode register
  always_ff @(posedge clk) begin
    if (srst) begin
      service_loss_limit <= SERVICE_LOSS_NORMAL;
      queue_bytes        <= QUEUE_BYTES_LARGE;
      burst_max_words    <= BURST_MAX_LONG;
    end else begin
      service_loss_limit <= next_mode_zero[TEST_BIT] ? SERVICE_LOSS_TEST
                                                     : SERVICE_LOSS_NORMAL;
      queue_bytes        <= next_mode_zero[SMALL_QUEUE_BIT] ? QUEUE_BYTES_SMALL
                                                            : QUEUE_BYTES_LARGE;
      burst_max_words    <= next_mode_zero[SHORT_BURST_BIT] ? BURST_MAX_SHORT
                                                            : BURST_MAX_LONG;
    end
  end

  // Parity unit; host input parity is never checked
  assign tx_in_b.data  = host_tx_data;
  assign tx_in_b.par   = host_tx_par;
  assign tx_in_b.valid = host_tx_valid;
  assign rx_in_b.data  = ind_rx_data;
  assign rx_in_b.par   = ind_rx_par;
  assign rx_in_b.valid = ind_rx_valid;

  simz_parity u_par (
    .clk         (clk),
    .srst        (srst),
    .flow_en     (mode_zero[FLOW_BIT]),
    .rx_in_frame (ind_rx_in_frame),
    .tx_in       (tx_in_b),
    .tx_out      (tx_out_b),
    .rx_in       (rx_in_b),
    .rx_err      (rx_par_err)
  );

  assign req_tx_data  = tx_out_b.data;
  assign req_tx_par   = tx_out_b.par;
  assign req_tx_valid = tx_out_b.valid;

  // Host bus word: lane order then fresh odd parity per byte
  assign next_word = mode_zero[ORDER_BIT] ? lane_swap(host_out_word)
                                          : host_out_word;

  always_ff @(posedge clk) begin
    if (srst) begin
      host_bus_word <= 32'h0000_0000;
      host_bus_par  <= 4'hF;
    end else begin
      host_bus_word <= next_word;
      for (int i = 0; i < 4; i++) begin
        host_bus_par[i] <= odd_par(next_word[8*i +: 8]);
      end
    end
  end
endmodule

/* pkg/simz_pkg.sv */
/*
  Package for the system-interface mode register block: offsets, field
  positions, reset values and timing counts.
  Assumes a single 100 MHz clock domain.
*/
package simz_pkg;
  localparam logic [8:0] MODE_ZERO_OFFSET = 9'h100;
  localparam logic [8:0] CTRL_OFFSET      = 9'h120;
  localparam logic [8:0] STAT_OFFSET      = 9'h121;

  localparam int TEST_BIT   = 0;
  localparam int FAST_CLK_BIT    = 1;
  localparam int MASTER_RST_BIT  = 2;
  localparam int FLOW_BIT        = 3;
  localparam int ORDER_BIT       = 4;
  localparam int VIRTUAL_BIT     = 5;
  localparam int SMALL_QUEUE_BIT = 6;
  localparam int SHORT_BURST_BIT = 7;

  localparam int CTRL_BUS_PAR_BIT = 0;

  localparam int STAT_RX_PAR_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  localparam logic [7:0] MODE_ZERO_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET      = 8'h00;

  localparam logic [7:0] SERVICE_LOSS_NORMAL = 8'hFF;
  localparam logic [7:0] SERVICE_LOSS_TEST   = 8'h04;

  localparam logic [3:0] MASTER_RST_CYCLES = 4'h8;

  localparam logic [12:0] QUEUE_BYTES_LARGE = 13'h1000;
  localparam logic [12:0] QUEUE_BYTES_SMALL = 13'h0400;

  localparam logic [3:0] BURST_MAX_LONG  = 4'h8;
  localparam logic [3:0] BURST_MAX_SHORT = 4'h4;

  typedef enum logic [1:0] {
    SIMZ_RST_IDLE = 2'b01,
    SIMZ_RST_BUSY = 2'b10
  } simz_rst_e;
endpackage

/* pkg/simz_par_if.sv */
/*
  Interface carrying one parity-protected byte between modules.
  Assumes both ends share clk.
*/
`timescale 1ns/1ps
interface simz_par_if;
  logic [7:0] data;
  logic       par;
  logic       valid;
  modport src (output data, output par, output valid);
  modport dst (input data, input par, input valid);
endinterface

/* hdl/simz_parity.sv */
/*
  Odd-parity unit: generates transmit parity unless flow_en forwards it, checks receive parity only with flow_en set.
  Assumes inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
module simz_parity (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Control
  input  wire logic flow_en,
  input  wire logic rx_in_frame,
  // Byte paths
  simz_par_if.dst   tx_in,
  simz_par_if.src   tx_out,
  simz_par_if.dst   rx_in,
  // Result
  output logic      rx_err
);
  import simz_pkg::*;

  function automatic logic odd_par(input logic [7:0] d);
    return ~(^d);
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_out.data  <= 8'h00;
      tx_out.par   <= 1'b1;
      tx_out.valid <= 1'b0;
    end else begin
      tx_out.data  <= tx_in.data;
      tx_out.valid <= tx_in.valid;
      tx_out.par   <= flow_en ? tx_in.par : odd_par(tx_in.data);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_err <= 1'b0;
    end else begin
      rx_err <= flow_en && rx_in.valid && rx_in_frame
                && (rx_in.par != odd_par(rx_in.data));
    end
  end
endmodule

/* verif/simz_host_model.sv */
/* Host bus model: feeds transmit bytes and host words.
   Assumes clk shared with the mode register block. */
`timescale 1ns/1ps
module simz_host_model (
  // Clock and control
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic host_en,
  input  wire logic host_flip,
  // Host side data
  output logic [7:0]  host_tx_data,
  output logic        host_tx_par,
  output logic        host_tx_valid,
  output logic [31:0] host_out_word
);
  always_ff @(posedge clk) begin
    if (srst) begin
      host_tx_valid <= 1'b0;
      host_tx_data  <= 8'h00;
      host_out_word <= 32'h1234_5678;
    end else begin
      host_tx_valid <= host_en;
      // Idle bus shows the inverse of the last byte
      host_tx_data  <= host_en ? host_tx_data + 8'h35 : ~host_tx_data;
      host_out_word <= {host_out_word[23:0], host_out_word[31:24] + 8'h5B};
    end
  end
  // Bad parity only when commanded
  assign host_tx_par = ~^host_tx_data ^ host_flip;
endmodule

/* verif/simz_mode_assertions.sv */
/* Port checker for the mode register block.
   Assumes attachment by the bind at the foot. */
`timescale 1ns/1ps
module simz_mode_assertions
  import simz_pkg::*;
(
  // Clock and register port
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [8:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Controls
  input wire logic        test_mode,
  input wire logic [7:0]  service_loss_limit,
  input wire logic        fast_host_clock_opt,
  input wire logic        machines_stop,
  input wire logic        virtual_addressing_select,
  input wire logic [12:0] queue_bytes,
  input wire logic [3:0]  burst_max_words,
  // Data paths
  input wire logic [7:0]  host_tx_data,
  input wire logic        host_tx_par,
  input wire logic        host_tx_valid,
  input wire logic [7:0]  req_tx_data,
  input wire logic        req_tx_par,
  input wire logic [31:0] host_out_word,
  input wire logic [31:0] host_bus_word,
  input wire logic [3:0]  host_bus_par
);
  logic [7:0] sh;
  logic       fl;
  logic       ord;
  assign fl  = sh[FLOW_BIT];
  assign ord = sh[ORDER_BIT];
  always_ff @(posedge clk) begin
    if (srst) sh <= 8'h00;
    else if (reg_wr && reg_addr == MODE_ZERO_OFFSET) sh <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_svc;
    service_loss_limit == (sh[TEST_BIT] ? SERVICE_LOSS_TEST : SERVICE_LOSS_NORMAL);
  endproperty
  a_svc: assert property (p_svc) else $error("service limit wrong");
  property p_dec;
    {test_mode, fast_host_clock_opt, virtual_addressing_select} == {sh[0], sh[1], sh[5]}
    && queue_bytes == (sh[SMALL_QUEUE_BIT] ? QUEUE_BYTES_SMALL : QUEUE_BYTES_LARGE)
    && burst_max_words == (sh[SHORT_BURST_BIT] ? BURST_MAX_SHORT : BURST_MAX_LONG);
  endproperty
  a_dec: assert property (p_dec) else $error("mode decode wrong");
  property p_go;
    reg_wr && reg_addr == MODE_ZERO_OFFSET && reg_wdata[MASTER_RST_BIT] && !machines_stop
    |=> machines_stop;
  endproperty
  a_go: assert property (p_go) else $error("master reset not started");
  property p_len;
    $rose(machines_stop) |-> machines_stop [*8] ##1 !machines_stop;
  endproperty
  a_len: assert property (p_len) else $error("master reset length");
  property p_fwd;
    !$past(srst) && $past(host_tx_valid) && $past(fl) |-> req_tx_par == $past(host_tx_par);
  endproperty
  a_fwd: assert property (p_fwd) else $error("parity not forwarded");
  property p_gen;
    !$past(srst) && $past(host_tx_valid) && !$past(fl) |-> req_tx_par == ~^req_tx_data;
  endproperty
  a_gen: assert property (p_gen) else $error("parity not regenerated");
  property p_hpar;
    host_bus_par == {~^host_bus_word[31:24], ~^host_bus_word[23:16],
                     ~^host_bus_word[15:8], ~^host_bus_word[7:0]};
  endproperty
  a_hpar: assert property (p_hpar) else $error("host bus parity");
  property p_ord;
    !$past(srst) |-> host_bus_word == ($past(ord) ? {$past(host_out_word[7:0]),
      $past(host_out_word[15:8]), $past(host_out_word[23:16]),
      $past(host_out_word[31:24])} : $past(host_out_word));
  endproperty
  a_ord: assert property (p_ord) else $error("byte order");
  property p_rd;
    reg_rd && reg_addr == MODE_ZERO_OFFSET |=> (reg_rdata & 8'hFB) == (sh & 8'hFB);
  endproperty
  a_rd: assert property (p_rd) else $error("mode readback");
endmodule
bind simz_mode_regs simz_mode_assertions simz_mode_assertions_inst (.*);

/* verif/tb.sv */
/* Self-checking bench for the mode register block.
   Assumes the host model on the host side. */
`timescale 1ns/1ps
module tb;
  import simz_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, host_en = 1'b0;
  logic        host_flip = 1'b0, ind_rx_par = 1'b0, ind_rx_valid = 1'b0, ind_rx_in_frame = 1'b0;
  logic        desc_par_fault = 1'b0, test_mode, fast_host_clock_opt, machines_stop;
  logic        sysif_regs_init, virtual_addressing_select, control_bus_parity_enable;
  logic        req_tx_par, req_tx_valid, host_tx_par, host_tx_valid;
  logic [8:0]  reg_addr = 9'h000;
  logic [7:0]  reg_wdata = 8'h00, ind_rx_data = 8'h00, reg_rdata, service_loss_limit;
  logic [7:0]  host_tx_data, req_tx_data;
  logic [12:0] queue_bytes;
  logic [3:0]  burst_max_words, host_bus_par;
  logic [31:0] host_out_word, host_bus_word;
  logic [7:0]  mv [5] = '{8'h01, 8'h02, 8'h30, 8'h40, 8'h80};
  int          fail_count = 0, checks_done = 0, n;
  simz_mode_regs simz_mode_regs_inst (.*);
  simz_host_model simz_host_model_inst (.*);
  initial forever #5 clk = ~clk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [8:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(logic [8:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk("reg read", reg_rdata, e);
  endtask
  task automatic rx(logic [7:0] d, logic p, logic f);
    @(posedge clk);
    ind_rx_data     <= d;
    ind_rx_par      <= p;
    ind_rx_in_frame <= f;
    ind_rx_valid    <= 1'b1;
    @(posedge clk);
    ind_rx_valid    <= 1'b0;
    ind_rx_data     <= ~d;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(MODE_ZERO_OFFSET, 8'h00);
    rd(STAT_OFFSET, 8'h00);
    rd(9'h1FF, 8'h00);
    $display("test reset done");
    foreach (mv[i]) begin
      wr(MODE_ZERO_OFFSET, mv[i]);
      rd(MODE_ZERO_OFFSET, mv[i]);
      chk("svc", service_loss_limit, mv[i][0] ? SERVICE_LOSS_TEST : SERVICE_LOSS_NORMAL);
      chk("queue", queue_bytes, mv[i][6] ? QUEUE_BYTES_SMALL : QUEUE_BYTES_LARGE);
      chk("burst", burst_max_words, mv[i][7] ? BURST_MAX_SHORT : BURST_MAX_LONG);
      chk("addr mode", {fast_host_clock_opt, virtual_addressing_select}, {mv[i][1], mv[i][5]});
    end
    $display("test fields done");
    wr(CTRL_OFFSET, 8'h01);
    host_en   <= 1'b1;
    host_flip <= 1'b1;
    wr(MODE_ZERO_OFFSET, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk("gen par", req_tx_par, ~^req_tx_data);
    chk("tx valid", req_tx_valid, 1'b1);
    wr(MODE_ZERO_OFFSET, 8'h08);
    repeat (3) @(posedge clk);
    #1 chk("fwd par", req_tx_par, ^req_tx_data);
    chk("ctrl parity", control_bus_parity_enable, 1'b1);
    rd(STAT_OFFSET, 8'h00);
    $display("test transmit done");
    rx(8'h5A, 1'b0, 1'b0);
    rd(STAT_OFFSET, 8'h00);
    rx(8'h5A, 1'b1, 1'b1);
    rd(STAT_OFFSET, 8'h00);
    rx(8'h5A, 1'b0, 1'b1);
    rd(STAT_OFFSET, 8'h01);
    wr(STAT_OFFSET, 8'h01);
    @(posedge clk);
    desc_par_fault <= 1'b1;
    @(posedge clk);
    desc_par_fault <= 1'b0;
    repeat (2) @(posedge clk);
    rd(STAT_OFFSET, 8'h02);
    wr(STAT_OFFSET, 8'h03);
    wr(MODE_ZERO_OFFSET, 8'h00);
    rx(8'h5A, 1'b0, 1'b1);
    rd(STAT_OFFSET, 8'h00);
    $display("test receive done");
    wr(MODE_ZERO_OFFSET, 8'h04);
    #1 chk("stop", machines_stop, 1'b1);
    chk("regs init", sysif_regs_init, 1'b1);
    rd(STAT_OFFSET, 8'h04);
    n = 0;
    while (machines_stop !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      fail_count++;
    end
    rd(MODE_ZERO_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h00);
    $display("test master reset done");
    wr(MODE_ZERO_OFFSET, 8'h08);
    for (n = 0; n < 64; n++) begin
      rx(n[7:0], ~^n[7:0], 1'b1);
    end
    rd(STAT_OFFSET, 8'h00);
    $display("test self frame done");
    print_verdict();
  end
endmodule
